// >>> src/error_second_monitor.sv
// per-second performance classification and sequence result counting
// assumes receive status and frame strobes come from logic on i_clock
//
// How it works
// [R1] available seconds with any pattern error count as errored seconds
// [R2] ratio at least 1e-3, frame loss or signal loss make a severe second
// [R3] link down, remote fault, frame loss or errored frames make an alarm second
// [R4] ten severe-or-alarm seconds in a row start unavailable time from the first
// [R5] ten non-severe seconds in a row end unavailable time before the first
// [R6] pending seconds counted as before, then corrected when decided
// [R7] available time equals total time minus unavailable time
// [R8] total time advances only while power is good
// [R9] available seconds without any error count as error-free
// [R10] transmitted test frames carry a running sequence number
// [R11] each received frame except the late frame of R13 sets the next expected sequence number
// [R12] four in-order frames are needed to gain sequence sync; a late-by-one pair between them does not break the run
// [R13] a frame late by exactly one place is a sequence error
// [R14] any other mismatch is sequence sync loss
// [R15] a stop mid-interval discards the incomplete interval
// [R16] after stop, final counts revert to the last completed interval
// [R17] seconds align to start; all counters clear at start
// [R18] severe ratio is pattern errors over bits checked in that second
`timescale 1ns/1ps
module error_second_monitor #(
   parameter int unsigned CYCLES_PER_SECOND = esm_pkg::CYCLES_PER_SECOND,
   parameter int unsigned INTERVAL_SECONDS = esm_pkg::INTERVAL_SECONDS,
   parameter int unsigned SEQ_W = esm_pkg::SEQ_W
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // measurement control
   input wire logic i_meas_run,
   input wire logic i_power_ok,
   // receive status, per cycle
   input wire logic [7:0] i_bits_checked,
   input wire logic [7:0] i_pattern_errors,
   input wire logic i_link_up,
   input wire logic i_remote_fault,
   input wire logic i_frame_loss,
   input wire logic i_signal_loss,
   input wire logic i_errored_frame,
   // test frames
   input wire logic i_tx_frame,
   output logic [SEQ_W-1:0] o_tx_seq,
   input wire logic i_rx_frame_valid,
   input wire logic [SEQ_W-1:0] i_rx_seq,
   // results
   output logic [31:0] o_total_seconds,
   output logic [31:0] o_unavailable_time,
   output logic [31:0] o_available_time,
   output logic [31:0] o_errored_second,
   output logic [31:0] o_severe_error_second,
   output logic [31:0] o_alarm_second,
   output logic [31:0] o_error_free_second,
   output logic [31:0] o_seq_errors,
   output logic [31:0] o_sync_losses,
   output logic [31:0] o_intervals_done,
   output logic o_in_sync,
   output logic o_unavailable,
   output logic o_second_tick
);
   typedef struct packed {
      logic run_d;
      esm_pkg::avail_state_t state;
      logic [3:0] run_len;
      logic [3:0] pend_es;
      logic [3:0] pend_ses;
      logic [3:0] pend_als;
      logic [3:0] pend_efs;
      logic [31:0] err_acc;
      logic [31:0] bit_acc;
      logic los_seen;
      logic lof_seen;
      logic alarm_seen;
      logic seq_seen;
      logic [31:0] interval_sec;
      logic [31:0] intervals;
      logic tick_d;
      esm_pkg::counts_t live;
      esm_pkg::counts_t saved;
   } mon_state_t;

   localparam mon_state_t RESET_STATE = '{state: esm_pkg::AVAIL_ST, default: '0};
   localparam logic [3:0] RUN_LAST = 4'(esm_pkg::UNAVAIL_RUN_SECONDS - 1);
   localparam logic [31:0] RUN_SECONDS = 32'(esm_pkg::UNAVAIL_RUN_SECONDS);

   mon_state_t st_reg;
   mon_state_t st_next;
   logic sec_tick;
   logic start;
   logic stop;
   logic counting;
   logic [31:0] sec_err;
   logic [31:0] sec_bits;
   logic [63:0] err_scaled;
   logic sec_es;
   logic sec_ses;
   logic sec_als;
   logic sec_efs;
   logic sec_bad;

   seq_status_if seq_status ();

   assign start = i_meas_run && !st_reg.run_d;
   assign stop = !i_meas_run && st_reg.run_d;

   second_timebase #(.CYCLES(CYCLES_PER_SECOND)) timebase (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_clear(start),
      .i_enable(i_meas_run && i_power_ok),
      .o_tick(sec_tick)
   );

   sequence_checker #(.SEQ_W(SEQ_W)) seq_check (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_clear(start),
      .i_tx_frame(i_tx_frame),
      .o_tx_seq(o_tx_seq),
      .i_rx_valid(i_rx_frame_valid),
      .i_rx_seq(i_rx_seq),
      .status(seq_status)
   );

   assign counting = sec_tick && st_reg.run_d && i_meas_run;

   // per-second figures include this cycle's inputs
   assign sec_err = st_reg.err_acc + 32'(i_pattern_errors);
   assign sec_bits = st_reg.bit_acc + 32'(i_bits_checked);
   assign err_scaled = 64'(sec_err) * 64'(esm_pkg::SES_RATIO_INVERSE);
   assign sec_es = sec_err != 32'h0; // R1
   assign sec_ses = (sec_bits != 32'h0 && err_scaled >= 64'(sec_bits)) // R18
      || st_reg.lof_seen || st_reg.los_seen || i_frame_loss || i_signal_loss; // R2
   assign sec_als = st_reg.alarm_seen || !i_link_up || i_remote_fault || i_frame_loss
      || i_errored_frame; // R3
   assign sec_efs = !sec_es && !sec_ses && !sec_als && !st_reg.seq_seen
      && !seq_status.seq_error && !seq_status.sync_loss; // R9
   assign sec_bad = sec_ses || sec_als;

   always_comb begin
      st_next = st_reg;
      st_next.run_d = i_meas_run;
      st_next.tick_d = counting;
      if (start) begin
         st_next = RESET_STATE; // R17
         st_next.run_d = 1'b1;
      end else if (stop) begin
         // partial interval is dropped
         st_next.live = st_reg.saved; // R15 R16
      end else if (st_reg.run_d) begin
         st_next.err_acc = sec_err;
         st_next.bit_acc = sec_bits;
         st_next.los_seen = st_reg.los_seen || i_signal_loss;
         st_next.lof_seen = st_reg.lof_seen || i_frame_loss;
         st_next.alarm_seen = sec_als;
         st_next.seq_seen = st_reg.seq_seen || seq_status.seq_error || seq_status.sync_loss;
         if (seq_status.seq_error) begin
            st_next.live.seq_err = st_reg.live.seq_err + 32'h1; // R13
         end
         if (seq_status.sync_loss) begin
            st_next.live.sync_loss = st_reg.live.sync_loss + 32'h1; // R14
         end
         if (counting) begin
            st_next.err_acc = 32'h0;
            st_next.bit_acc = 32'h0;
            st_next.los_seen = 1'b0;
            st_next.lof_seen = 1'b0;
            st_next.alarm_seen = 1'b0;
            st_next.seq_seen = 1'b0;
            st_next.live.total = st_reg.live.total + 32'h1; // R8
            case (st_reg.state)
               esm_pkg::AVAIL_ST: begin
                  // pending entry seconds are counted as available
                  st_next.live.avail = st_reg.live.avail + 32'h1; // R6
                  st_next.live.es = st_reg.live.es + 32'(sec_es); // R1
                  st_next.live.severe_error_second = st_reg.live.severe_error_second + 32'(sec_ses); // R2
                  st_next.live.alarm_second = st_reg.live.alarm_second + 32'(sec_als); // R3
                  st_next.live.error_free_second = st_reg.live.error_free_second + 32'(sec_efs); // R9
                  if (!sec_bad) begin
                     st_next.run_len = 4'h0;
                     st_next.pend_es = 4'h0;
                     st_next.pend_ses = 4'h0;
                     st_next.pend_als = 4'h0;
                     st_next.pend_efs = 4'h0;
                  end else if (st_reg.run_len == RUN_LAST) begin
                     // the whole run becomes unavailable, retroactively
                     st_next.state = esm_pkg::UNAVAIL_ST; // R4
                     st_next.live.unavailable_time = st_reg.live.unavailable_time + RUN_SECONDS; // R4
                     st_next.live.avail = st_reg.live.avail + 32'h1 - RUN_SECONDS; // R7
                     st_next.live.es = st_reg.live.es - 32'(st_reg.pend_es); // R6
                     st_next.live.severe_error_second = st_reg.live.severe_error_second - 32'(st_reg.pend_ses);
                     st_next.live.alarm_second = st_reg.live.alarm_second - 32'(st_reg.pend_als);
                     st_next.live.error_free_second = st_reg.live.error_free_second - 32'(st_reg.pend_efs);
                     st_next.run_len = 4'h0;
                     st_next.pend_es = 4'h0;
                     st_next.pend_ses = 4'h0;
                     st_next.pend_als = 4'h0;
                     st_next.pend_efs = 4'h0;
                  end else begin
                     st_next.run_len = st_reg.run_len + 4'h1;
                     st_next.pend_es = st_reg.pend_es + 4'(sec_es);
                     st_next.pend_ses = st_reg.pend_ses + 4'(sec_ses);
                     st_next.pend_als = st_reg.pend_als + 4'(sec_als);
                     st_next.pend_efs = st_reg.pend_efs + 4'(sec_efs);
                  end
               end
               esm_pkg::UNAVAIL_ST: begin
                  // pending exit seconds are counted as unavailable
                  st_next.live.unavailable_time = st_reg.live.unavailable_time + 32'h1; // R6
                  if (sec_ses) begin
                     st_next.run_len = 4'h0;
                     st_next.pend_es = 4'h0;
                     st_next.pend_als = 4'h0;
                     st_next.pend_efs = 4'h0;
                  end else if (st_reg.run_len == RUN_LAST) begin
                     st_next.state = esm_pkg::AVAIL_ST; // R5
                     st_next.live.unavailable_time = st_reg.live.unavailable_time + 32'h1 - RUN_SECONDS; // R5
                     st_next.live.avail = st_reg.live.avail + RUN_SECONDS; // R7
                     st_next.live.es = st_reg.live.es + 32'(st_reg.pend_es) + 32'(sec_es);
                     st_next.live.alarm_second = st_reg.live.alarm_second + 32'(st_reg.pend_als) + 32'(sec_als);
                     st_next.live.error_free_second = st_reg.live.error_free_second + 32'(st_reg.pend_efs) + 32'(sec_efs);
                     st_next.run_len = 4'h0;
                     st_next.pend_es = 4'h0;
                     st_next.pend_als = 4'h0;
                     st_next.pend_efs = 4'h0;
                  end else begin
                     st_next.run_len = st_reg.run_len + 4'h1;
                     st_next.pend_es = st_reg.pend_es + 4'(sec_es);
                     st_next.pend_als = st_reg.pend_als + 4'(sec_als);
                     st_next.pend_efs = st_reg.pend_efs + 4'(sec_efs);
                  end
               end
               default: begin
                  st_next.state = esm_pkg::AVAIL_ST;
               end
            endcase
            if (st_reg.interval_sec == 32'(INTERVAL_SECONDS - 1)) begin
               st_next.interval_sec = 32'h0;
               st_next.intervals = st_reg.intervals + 32'h1;
               st_next.saved = st_next.live; // R16
            end else begin
               st_next.interval_sec = st_reg.interval_sec + 32'h1;
            end
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= RESET_STATE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_total_seconds = st_reg.live.total;
   assign o_unavailable_time = st_reg.live.unavailable_time;
   assign o_available_time = st_reg.live.avail;
   assign o_errored_second = st_reg.live.es;
   assign o_severe_error_second = st_reg.live.severe_error_second;
   assign o_alarm_second = st_reg.live.alarm_second;
   assign o_error_free_second = st_reg.live.error_free_second;
   assign o_seq_errors = st_reg.live.seq_err;
   assign o_sync_losses = st_reg.live.sync_loss;
   assign o_intervals_done = st_reg.intervals;
   assign o_in_sync = seq_status.in_sync;
   assign o_unavailable = st_reg.state == esm_pkg::UNAVAIL_ST;
   assign o_second_tick = st_reg.tick_d;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   chk_avail_formula: assert property (st_reg.live.avail == st_reg.live.total - st_reg.live.unavailable_time) // R7
      else $error("available time differs from total minus unavailable");
   chk_start_clears: assert property (start |=> st_reg.live == '0 && st_reg.intervals == 32'h0) // R17
      else $error("counters not cleared at start");
   chk_total_step: assert property (counting |=> st_reg.live.total == $past(st_reg.live.total) + 32'h1) // R8
      else $error("total time did not advance on a second");
   chk_es_count: assert property (counting && !sec_bad && sec_es
      && st_reg.state == esm_pkg::AVAIL_ST |=> st_reg.live.es == $past(st_reg.live.es) + 32'h1) // R1
      else $error("errored second not counted");
   chk_ses_pending: assert property (counting && sec_ses && st_reg.run_len != RUN_LAST
      && st_reg.state == esm_pkg::AVAIL_ST |=> st_reg.live.severe_error_second == $past(st_reg.live.severe_error_second) + 32'h1) // R2
      else $error("pending severe second not counted as available");
   chk_unavail_entry: assert property (counting && sec_bad && st_reg.run_len == RUN_LAST
      && st_reg.state == esm_pkg::AVAIL_ST |=> o_unavailable
      && st_reg.live.unavailable_time == $past(st_reg.live.unavailable_time) + RUN_SECONDS) // R4
      else $error("unavailable entry wrong");
   chk_unavail_exit: assert property (counting && !sec_ses && st_reg.run_len == RUN_LAST
      && st_reg.state == esm_pkg::UNAVAIL_ST |=> !o_unavailable
      && st_reg.live.unavailable_time == $past(st_reg.live.unavailable_time) + 32'h1 - RUN_SECONDS) // R5
      else $error("unavailable exit wrong");
   chk_efs_count: assert property (counting && sec_efs && st_reg.state == esm_pkg::AVAIL_ST
      |=> st_reg.live.error_free_second == $past(st_reg.live.error_free_second) + 32'h1) // R9
      else $error("error-free second not counted");
   chk_stop_restore: assert property (stop |=> st_reg.live == $past(st_reg.saved)) // R15
      else $error("partial interval not discarded at stop");

   cov_enter_unavail: cover property ($rose(o_unavailable));
   cov_leave_unavail: cover property ($fell(o_unavailable));
   cov_interval_done: cover property (st_reg.intervals != 32'h0 ##1 stop);
   cov_sync_loss: cover property (seq_status.sync_loss);
endmodule // error_second_monitor

// >>> pkg/esm_pkg.sv
// constants and types for the error-second and sequence monitor
// assumes a single 100 MHz clock; nothing is imported, users write esm_pkg::name
package esm_pkg;
   localparam int unsigned CLOCK_PERIOD_NS = 10;
   localparam int unsigned ONE_SECOND_NS = 1000000000;
   localparam int unsigned CYCLES_PER_SECOND = ONE_SECOND_NS / CLOCK_PERIOD_NS;
   localparam int unsigned UNAVAIL_RUN_SECONDS = 10;
   localparam int unsigned SES_RATIO_INVERSE = 1000;
   localparam int unsigned SEQ_WINDOW_FRAMES = 4;
   localparam int unsigned INTERVAL_SECONDS = 900;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned SEQ_W = 16;
   localparam logic [31:0] COUNT_RESET = 32'h0;

   typedef enum logic [1:0] {
      AVAIL_ST = 2'b01,
      UNAVAIL_ST = 2'b10
   } avail_state_t;

   typedef struct packed {
      logic [CNT_W-1:0] total;
      logic [CNT_W-1:0] unavailable_time;
      logic [CNT_W-1:0] avail;
      logic [CNT_W-1:0] es;
      logic [CNT_W-1:0] severe_error_second;
      logic [CNT_W-1:0] alarm_second;
      logic [CNT_W-1:0] error_free_second;
      logic [CNT_W-1:0] seq_err;
      logic [CNT_W-1:0] sync_loss;
   } counts_t;
endpackage

// >>> pkg/seq_status_if.sv
// sequence check results passed from the checker to the second classifier
// one clock domain; pulses last one cycle
`timescale 1ns/1ps
interface seq_status_if;
   logic seq_error;
   logic sync_loss;
   logic in_sync;
   modport source (output seq_error, output sync_loss, output in_sync);
   modport sink (input seq_error, input sync_loss, input in_sync);
endinterface

// >>> src/second_timebase.sv
// one-second enable pulse divided from the system clock
// clear restarts the second so boundaries align with measurement start
`timescale 1ns/1ps
module second_timebase #(
   parameter int unsigned CYCLES = esm_pkg::CYCLES_PER_SECOND
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // control
   input wire logic i_clear,
   input wire logic i_enable,
   // pulse
   output logic o_tick
);
   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } tb_state_t;

   tb_state_t st_reg;
   tb_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (i_clear) begin
         st_next.count = 32'h0;
      end else if (i_enable) begin
         // held while power is lost, so that time is not totalled
         if (st_reg.count == 32'(CYCLES - 1)) begin // R8
            st_next.count = 32'h0;
            st_next.tick = 1'b1; // R17
         end else begin
            st_next.count = st_reg.count + 32'h1;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_tick = st_reg.tick;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   chk_tick_power_hold: assert property (!i_enable |=> !o_tick) // R8
      else $error("second pulse while timebase disabled");
   chk_tick_after_clear: assert property (i_clear |=> !o_tick && st_reg.count == 32'h0) // R17
      else $error("second pulse not realigned by clear");
endmodule // second_timebase

// >>> src/sequence_checker.sv
// transmit sequence numbering and receive sequence checking
// frames arrive as one-cycle strobes on the same clock
`timescale 1ns/1ps
module sequence_checker #(
   parameter int unsigned SEQ_W = esm_pkg::SEQ_W
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_clear,
   // transmit side
   input wire logic i_tx_frame,
   output logic [SEQ_W-1:0] o_tx_seq,
   // receive side
   input wire logic i_rx_valid,
   input wire logic [SEQ_W-1:0] i_rx_seq,
   // results
   seq_status_if.source status
);
   typedef struct packed {
      logic [SEQ_W-1:0] tx_seq;
      logic [SEQ_W-1:0] expected;
      logic [SEQ_W-1:0] skipped;
      logic have_ref;
      logic pend;
      logic [2:0] good_run;
      logic in_sync;
      logic seq_err;
      logic sync_loss;
   } sc_state_t;

   sc_state_t st_reg;
   sc_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.seq_err = 1'b0;
      st_next.sync_loss = 1'b0;
      if (i_clear) begin
         st_next = '0;
      end else begin
         if (i_tx_frame) begin
            st_next.tx_seq = st_reg.tx_seq + SEQ_W'(1); // R10
         end
         if (i_rx_valid) begin
            if (!st_reg.have_ref) begin
               st_next.have_ref = 1'b1;
               st_next.expected = i_rx_seq + SEQ_W'(1); // R11
               st_next.good_run = 3'h1;
            end else if (st_reg.pend) begin
               st_next.pend = 1'b0;
               if (i_rx_seq == st_reg.skipped) begin
                  st_next.seq_err = 1'b1; // R13
               end else begin
                  st_next.sync_loss = 1'b1; // R14
                  st_next.in_sync = 1'b0;
                  st_next.good_run = 3'h0;
                  st_next.expected = i_rx_seq + SEQ_W'(1);
               end
            end else if (i_rx_seq == st_reg.expected) begin
               st_next.expected = i_rx_seq + SEQ_W'(1); // R11
               // sync needs a full window of in-order frames
               if (st_reg.good_run == 3'(esm_pkg::SEQ_WINDOW_FRAMES - 1)) begin
                  st_next.in_sync = 1'b1; // R12
               end else begin
                  st_next.good_run = st_reg.good_run + 3'h1;
               end
            end else if (i_rx_seq == st_reg.expected + SEQ_W'(1)) begin
               // one frame may be late by one place
               st_next.pend = 1'b1; // R13
               st_next.skipped = st_reg.expected;
               st_next.expected = i_rx_seq + SEQ_W'(1);
            end else begin
               st_next.sync_loss = 1'b1; // R14
               st_next.in_sync = 1'b0;
               st_next.good_run = 3'h0;
               st_next.expected = i_rx_seq + SEQ_W'(1);
            end
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_tx_seq = st_reg.tx_seq;
   assign status.seq_error = st_reg.seq_err;
   assign status.sync_loss = st_reg.sync_loss;
   assign status.in_sync = st_reg.in_sync;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   chk_seq_displaced: assert property (!i_clear && i_rx_valid && st_reg.have_ref && st_reg.pend
      && i_rx_seq == st_reg.skipped |=> st_reg.seq_err && !st_reg.sync_loss) // R13
      else $error("late frame not reported as sequence error");
   chk_sync_loss_gap: assert property (!i_clear && i_rx_valid && st_reg.have_ref && !st_reg.pend
      && i_rx_seq != st_reg.expected && i_rx_seq != st_reg.expected + SEQ_W'(1)
      |=> st_reg.sync_loss && !st_reg.in_sync) // R14
      else $error("sequence gap not reported as sync loss");
   chk_sync_window: assert property ($rose(st_reg.in_sync) |-> $past(st_reg.good_run) == 3'h3) // R12
      else $error("sync regained without four in-order frames");
   cov_seq_error: cover property (st_reg.seq_err);
endmodule // sequence_checker

// >>> verification/rx_traffic_model.sv
// far-end test traffic: sequenced receive frames, one per call
// assumes the bench clock; strobes change just after a rising edge
`timescale 1ns/1ps
module rx_traffic_model (
   input wire logic i_clock,
   output logic o_valid,
   output logic [15:0] o_seq
);
   initial begin
      o_valid = 1'b0;
      o_seq = 16'hffff;
   end
   task automatic send_frame(input logic [15:0] s);
      @(posedge i_clock);
      o_valid <= 1'b1;
      o_seq <= s;
      @(posedge i_clock);
      o_valid <= 1'b0;
      // released line shows the inverse, not a stale number
      o_seq <= ~s;
   endtask
endmodule // rx_traffic_model

// >>> verification/tb_error_second_monitor.sv
// bench for error_second_monitor: classes, availability, power, sequence, stop
// assumes a 20-cycle second and a 12-second interval
`timescale 1ns/1ps
module tb_error_second_monitor;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic i_meas_run = 1'b0;
   logic i_power_ok = 1'b1;
   logic [7:0] i_pattern_errors = 8'h00;
   logic i_frame_loss = 1'b0;
   logic i_errored_frame = 1'b0;
   logic i_link_up = 1'b1;
   logic i_remote_fault = 1'b0;
   logic i_signal_loss = 1'b0;
   logic i_tx_frame = 1'b0;
   logic rx_valid;
   logic [15:0] rx_seq;
   logic [15:0] tx_seq;
   logic [31:0] tot, unavailable_time, avl, es, severe_error_second, alarm_second, error_free_second, sqe, sql, ivd;
   logic in_sync, unavail, tick;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   always #5 i_clock = ~i_clock;
   rx_traffic_model rx (.i_clock(i_clock), .o_valid(rx_valid), .o_seq(rx_seq));
   error_second_monitor #(.CYCLES_PER_SECOND(20), .INTERVAL_SECONDS(12), .SEQ_W(16)) uut (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_meas_run(i_meas_run), .i_power_ok(i_power_ok),
      .i_bits_checked(8'hff), .i_pattern_errors(i_pattern_errors), .i_link_up(i_link_up),
      .i_remote_fault(i_remote_fault), .i_frame_loss(i_frame_loss), .i_signal_loss(i_signal_loss),
      .i_errored_frame(i_errored_frame), .i_tx_frame(i_tx_frame), .o_tx_seq(tx_seq),
      .i_rx_frame_valid(rx_valid), .i_rx_seq(rx_seq), .o_total_seconds(tot),
      .o_unavailable_time(unavailable_time), .o_available_time(avl), .o_errored_second(es),
      .o_severe_error_second(severe_error_second), .o_alarm_second(alarm_second), .o_error_free_second(error_free_second),
      .o_seq_errors(sqe), .o_sync_losses(sql), .o_intervals_done(ivd), .o_in_sync(in_sync),
      .o_unavailable(unavail), .o_second_tick(tick));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic sec(input int n);
      repeat (n) begin
         do begin
            @(posedge i_clock);
            #1;
         end while (tick !== 1'b1);
      end
   endtask
   task automatic start();
      @(posedge i_clock);
      i_meas_run <= 1'b0;
      @(posedge i_clock);
      i_meas_run <= 1'b1;
      cyc(1);
   endtask
   task automatic pulse(input logic [7:0] n, input logic ef);
      @(posedge i_clock);
      i_pattern_errors <= n;
      i_errored_frame <= ef;
      @(posedge i_clock);
      i_pattern_errors <= 8'h00;
      i_errored_frame <= 1'b0;
   endtask
   // one-cycle fault in the next second, then wait for that second
   task automatic fault(input logic rf, input logic ld, input logic sl);
      @(posedge i_clock);
      i_remote_fault <= rf;
      i_link_up <= !ld;
      i_signal_loss <= sl;
      @(posedge i_clock);
      i_remote_fault <= 1'b0;
      i_link_up <= 1'b1;
      i_signal_loss <= 1'b0;
      sec(1);
   endtask
   task automatic test_classes();
      start();
      sec(1);
      chk("efs", error_free_second, 32'h1);
      chk("avail", avl, 32'h1);
      pulse(8'h01, 1'b0);
      sec(1);
      chk("es", es, 32'h1);
      chk("ses low ratio", severe_error_second, 32'h0);
      pulse(8'h06, 1'b0);
      sec(1);
      chk("ses", severe_error_second, 32'h1);
      chk("es", es, 32'h2);
      pulse(8'h00, 1'b1);
      sec(1);
      chk("als", alarm_second, 32'h1);
      chk("efs", error_free_second, 32'h1);
      fault(1'b1, 1'b0, 1'b0);
      chk("als remote fault", alarm_second, 32'h2);
      fault(1'b0, 1'b1, 1'b0);
      chk("als link down", alarm_second, 32'h3);
      fault(1'b0, 1'b0, 1'b1);
      chk("ses signal loss", severe_error_second, 32'h2);
      chk("als signal loss", alarm_second, 32'h3);
      @(posedge i_clock);
      i_power_ok <= 1'b0;
      cyc(60);
      chk("total unpowered", tot, 32'h7);
      @(posedge i_clock);
      i_power_ok <= 1'b1;
      sec(1);
      chk("total", tot, 32'h8);
   endtask
   task automatic test_unavail();
      start();
      @(posedge i_clock);
      i_frame_loss <= 1'b1;
      sec(10);
      chk("unavail", {31'h0, unavail}, 32'h1);
      chk("uat", unavailable_time, 32'ha);
      chk("ses pending", severe_error_second, 32'h0);
      chk("avail", avl, 32'h0);
      sec(2);
      @(posedge i_clock);
      i_frame_loss <= 1'b0;
      sec(11);
      chk("unavail", {31'h0, unavail}, 32'h0);
      chk("uat", unavailable_time, 32'hd);
      chk("efs", error_free_second, 32'ha);
      chk("avail", avl, 32'ha);
      sec(2);
      cyc(5);
      @(posedge i_clock);
      i_meas_run <= 1'b0;
      cyc(3);
      chk("total after stop", tot, 32'h18);
      chk("intervals", ivd, 32'h2);
      chk("avail after stop", avl, 32'hb);
   endtask
   task automatic test_seq();
      logic [15:0] s [8] = '{16'h1, 16'h2, 16'h4, 16'h3, 16'h5, 16'h6, 16'h7, 16'h8};
      logic [15:0] v;
      start();
      @(posedge i_clock);
      i_tx_frame <= 1'b1;
      @(posedge i_clock);
      i_tx_frame <= 1'b0;
      cyc(2);
      v = tx_seq;
      @(posedge i_clock);
      i_tx_frame <= 1'b1;
      @(posedge i_clock);
      i_tx_frame <= 1'b0;
      cyc(2);
      chk("tx seq", {16'h0, tx_seq}, {16'h0, v + 16'h1});
      foreach (s[i]) rx.send_frame(s[i]);
      cyc(3);
      chk("seq errors", sqe, 32'h1);
      chk("in sync", {31'h0, in_sync}, 32'h1);
      chk("sync losses", sql, 32'h0);
      rx.send_frame(16'h14);
      cyc(3);
      chk("sync losses", sql, 32'h1);
      chk("in sync", {31'h0, in_sync}, 32'h0);
   endtask
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge i_clock);
      i_nrst <= 1'b1;
      cyc(2);
      chk("total after reset", tot, 32'h0);
      test_classes();
      test_unavail();
      test_seq();
      print_verdict();
   end
endmodule // tb_error_second_monitor
